/* pcs_defines.svh */
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register selects
`define PCS_SEL_FUNC      4'h2
`define PCS_SEL_CONV      4'h3
`define PCS_SEL_STAT      4'h4

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define PCS_FN_CODE_LSB   0
`define PCS_FN_DCD_BIT    4
`define PCS_FN_DFD_BIT    5
`define PCS_CV_ABORT_BIT  2
`define PCS_CV_START_BIT  3
`define PCS_CV_DIS_BIT    4
`define PCS_ST_FAULT_LSB  0
`define PCS_ST_CLASS_LSB  3
`define PCS_ST_DONE_BIT   6
`define PCS_ST_DISC_BIT   7

////////////////////////////////////////////////////////////////////////////////
// Reset values and limits
`define PCS_REG_RESET     8'h00
`define PCS_FUNC_RESET    4'h0
`define PCS_CLASS_RESET   3'h0
`define PCS_CLASS_MAX     3'h4

////////////////////////////////////////////////////////////////////////////////
// Timing
`define PCS_CLK_HZ        25000000
`define PCS_OVERLOAD_MS   50
`define PCS_OVERLOAD_CYC  ((`PCS_OVERLOAD_MS * `PCS_CLK_HZ) / 1000)

`endif

/* pcs_fault_enc.sv */
`include "pcs_defines.svh"

module pcs_fault_enc
    import pcs_pkg::*;
#(
    parameter int unsigned OVERLOAD_CYCLES = `PCS_OVERLOAD_CYC
)
(
    input  wire logic  mclk,
    input  wire logic  rst,
    input  wire logic  thermal_shutdown_fault,
    input  wire logic  under_over_voltage_fault,
    input  wire logic  overload,
    input  wire logic  load_disc,
    input  wire logic  dc_disc_disable,
    output pcs_fault_t fault_code
);

    logic [31:0] ovl_cnt;
    logic        ovl_long;

    ////////////////////////////////////////////////////////////////////////////
    // Overload persistence timer
    always_ff @(posedge mclk)
    begin
        if (rst || !overload)
            ovl_cnt <= 32'h0000_0000;
        else if (ovl_cnt != OVERLOAD_CYCLES)
            ovl_cnt <= ovl_cnt + 32'h0000_0001;
    end

    assign ovl_long = (ovl_cnt == OVERLOAD_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // Fault code, thermal first
    always_ff @(posedge mclk)
    begin
        if (rst)
            fault_code <= PCS_FLT_NONE;
        else if (thermal_shutdown_fault)
            fault_code <= PCS_FLT_THERMAL;
        else if (under_over_voltage_fault)
            fault_code <= PCS_FLT_VOLTAGE;
        else if (ovl_long)
            fault_code <= PCS_FLT_OVERLOAD;
        else if (load_disc && !dc_disc_disable)
            fault_code <= PCS_FLT_LOAD_DISC;
        else
            fault_code <= PCS_FLT_NONE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_OVL_AFTER_HOLD : assert property (
        @(posedge mclk) disable iff (rst)
        (fault_code == PCS_FLT_OVERLOAD) |-> $past(ovl_cnt) == OVERLOAD_CYCLES
    ) else $error("Overload fault before hold time");

    AST_DCD_MASK : assert property (
        @(posedge mclk) disable iff (rst)
        $past(dc_disc_disable) |-> fault_code != PCS_FLT_LOAD_DISC
    ) else $error("Load disconnect reported while masked");

    AST_THERMAL_FIRST : assert property (
        @(posedge mclk) disable iff (rst)
        thermal_shutdown_fault |=> fault_code == PCS_FLT_THERMAL
    ) else $error("Thermal fault not reported");

endmodule

/* pcs_host_model.sv */
module pcs_host_model
(
    input  wire logic       mclk,
    output logic      [1:0] reg_port_sel,
    output logic      [3:0] reg_sel,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        reg_port_sel = 2'h0;
        reg_sel = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    ////////////////////////////////////////
    // Single byte write, data line scrambled once released
    task automatic wr(logic [1:0] p, logic [3:0] s, logic [7:0] d);
        @(negedge mclk);
        reg_port_sel = p;
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    ////////////////////////////////////////
    // Single byte read, bounded wait for the valid pulse
    task automatic rd(logic [1:0] p, logic [3:0] s,
                      output logic [7:0] d, output bit ok);
        int n;
        @(negedge mclk);
        reg_port_sel = p;
        reg_sel = s;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (reg_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata;
            end
            else
                @(negedge mclk);
        end
    endtask
endmodule

/* pcs_pkg.sv */
package pcs_pkg;

    typedef enum logic [3:0] {
        PCS_FN_DISABLE  = 4'h0,
        PCS_FN_DISC1    = 4'h1,
        PCS_FN_DISC2    = 4'h2,
        PCS_FN_VSAMPLE  = 4'h3,
        PCS_FN_LEGACY   = 4'h4,
        PCS_FN_CLASSIFY = 4'h5,
        PCS_FN_POWER_ON = 4'h6,
        PCS_FN_CSAMPLE  = 4'h7,
        PCS_FN_RAMPDOWN = 4'h8,
        PCS_FN_AC_LOW   = 4'h9,
        PCS_FN_AC_HIGH  = 4'hA,
        PCS_FN_ISAMPLE  = 4'hB,
        PCS_FN_TSAMPLE  = 4'hC
    } pcs_func_t;

    typedef enum logic [2:0] {
        PCS_FLT_NONE      = 3'h0,
        PCS_FLT_VOLTAGE   = 3'h1,
        PCS_FLT_THERMAL   = 3'h2,
        PCS_FLT_OVERLOAD  = 3'h3,
        PCS_FLT_LOAD_DISC = 3'h4
    } pcs_fault_t;

    typedef logic [12:0] pcs_ops_t;

endpackage

/* pcs_regs.sv */
// Functional notes
// - Four ports, each with own registers
// - Discovery fault disable masks discovery failure
// - DC disconnect disable stops DC disconnect
// - Code zero powers down, reset value
// - Codes one, two run discovery steps
// - Code three samples port voltage
// - Code four legacy, five classification
// - Code six powers port, seven continuous
// - Eight ramps down, nine/ten AC ops
// - Code eleven samples port current
// - Twelve samples temperature, spares idle
// - Port disable bit disables the port
// - Converter start bit self clears
// - Done sets on completion, clears on function write
// - Fault zero none, one voltage, two thermal
// - Fault three on long overload
// - Fault four load disconnect, no higher
`include "pcs_defines.svh"

module pcs_regs
    import pcs_pkg::*;
#(
    parameter int          NPORT           = 4,
    parameter int unsigned OVERLOAD_CYCLES = `PCS_OVERLOAD_CYC
)
(
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic [$clog2(NPORT)-1:0] reg_port_sel,
    input  wire logic [3:0]               reg_sel,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    output logic                          reg_rvalid,
    input  wire logic [NPORT-1:0]         func_complete,
    input  wire logic [NPORT-1:0]         disc_fail,
    input  wire logic [3*NPORT-1:0]       class_in,
    input  wire logic [NPORT-1:0]         thermal_shutdown_fault,
    input  wire logic [NPORT-1:0]         under_over_voltage_fault,
    input  wire logic [NPORT-1:0]         overload,
    input  wire logic [NPORT-1:0]         load_disc,
    output logic      [NPORT-1:0]         disc_fault_disable,
    output logic      [NPORT-1:0]         dc_disc_disable,
    output logic      [NPORT-1:0]         port_disable,
    output logic      [NPORT-1:0]         conv_start,
    output logic      [NPORT-1:0]         conv_abort,
    output logic      [NPORT-1:0]         port_reset,
    output logic      [NPORT-1:0]         discovery1_run,
    output logic      [NPORT-1:0]         discovery2_run,
    output logic      [NPORT-1:0]         volt_sample,
    output logic      [NPORT-1:0]         legacy_detect,
    output logic      [NPORT-1:0]         classify_run,
    output logic      [NPORT-1:0]         power_on,
    output logic      [NPORT-1:0]         cont_sample,
    output logic      [NPORT-1:0]         ramp_down,
    output logic      [NPORT-1:0]         ac_low,
    output logic      [NPORT-1:0]         ac_high,
    output logic      [NPORT-1:0]         curr_sample,
    output logic      [NPORT-1:0]         temp_sample
);

    localparam int PW = $clog2(NPORT);

    logic [3:0]       func      [NPORT];
    logic [2:0]       pclass    [NPORT];
    pcs_ops_t         op        [NPORT];
    pcs_fault_t       fault     [NPORT];
    logic [NPORT-1:0] dfd;
    logic [NPORT-1:0] dcd;
    logic [NPORT-1:0] pdis;
    logic [NPORT-1:0] conv_go;
    logic [NPORT-1:0] abort;
    logic [NPORT-1:0] done;
    logic [NPORT-1:0] disc_stat;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic wr_hit(input logic [PW-1:0] p,
                                    input logic [3:0]    sel);
        return reg_wr && (reg_port_sel == p) && (reg_sel == sel);
    endfunction

    function automatic pcs_ops_t op_decode(input logic [3:0] code,
                                           input logic       dis);
        if (dis)
            return 13'h0001;
        else if (code > PCS_FN_TSAMPLE)
            return 13'h0000;
        else
            return 13'h0001 << code;
    endfunction

    function automatic logic [2:0] class_clamp(input logic [2:0] c);
        return (c > `PCS_CLASS_MAX) ? `PCS_CLASS_RESET : c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Function control register
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (rst)
            begin
                func[i] <= `PCS_FUNC_RESET;
                dfd[i]  <= 1'b0;
                dcd[i]  <= 1'b0;
            end
            else if (wr_hit(PW'(i), `PCS_SEL_FUNC))
            begin
                func[i] <= reg_wdata[`PCS_FN_CODE_LSB +: 4];
                dfd[i]  <= reg_wdata[`PCS_FN_DFD_BIT];
                dcd[i]  <= reg_wdata[`PCS_FN_DCD_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable and converter control register
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (rst)
            begin
                pdis[i]    <= 1'b0;
                abort[i]   <= 1'b0;
                conv_go[i] <= 1'b0;
            end
            else if (wr_hit(PW'(i), `PCS_SEL_CONV))
            begin
                pdis[i]    <= reg_wdata[`PCS_CV_DIS_BIT];
                abort[i]   <= reg_wdata[`PCS_CV_ABORT_BIT];
                conv_go[i] <= reg_wdata[`PCS_CV_START_BIT]
                              && !reg_wdata[`PCS_CV_ABORT_BIT];
            end
            else
                conv_go[i] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Function decode
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (rst)
                op[i] <= 13'h0001;
            else
                op[i] <= op_decode(func[i], pdis[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Function done flag, set wins over clear
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (rst)
                done[i] <= 1'b0;
            else
                done[i] <= func_complete[i]
                           || (done[i] && !wr_hit(PW'(i), `PCS_SEL_FUNC));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Discovery status
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (rst)
                disc_stat[i] <= 1'b0;
            else
                disc_stat[i] <= disc_fail[i] && !dfd[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power class capture
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (rst || op[i][PCS_FN_DISABLE])
                pclass[i] <= `PCS_CLASS_RESET;
            else if (func_complete[i] && op[i][PCS_FN_CLASSIFY])
                pclass[i] <= class_clamp(class_in[3*i +: 3]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault encoders
    for (genvar g = 0; g < NPORT; g++)
    begin : g_fault
        pcs_fault_enc #(
            .OVERLOAD_CYCLES          (OVERLOAD_CYCLES)
        ) pcs_fault_enc_i (
            .mclk                     (mclk),
            .rst                      (rst),
            .thermal_shutdown_fault   (thermal_shutdown_fault[g]),
            .under_over_voltage_fault (under_over_voltage_fault[g]),
            .overload                 (overload[g]),
            .load_disc                (load_disc[g]),
            .dc_disc_disable          (dcd[g]),
            .fault_code               (fault[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    function automatic logic [7:0] read_word(input logic [PW-1:0] p,
                                             input logic [3:0]    sel);
        logic [7:0] w;
        w = `PCS_REG_RESET;
        if (sel == `PCS_SEL_FUNC)
        begin
            w[`PCS_FN_CODE_LSB +: 4] = func[p];
            w[`PCS_FN_DCD_BIT]       = dcd[p];
            w[`PCS_FN_DFD_BIT]       = dfd[p];
        end
        else if (sel == `PCS_SEL_CONV)
        begin
            w[`PCS_CV_ABORT_BIT] = abort[p];
            w[`PCS_CV_START_BIT] = conv_go[p];
            w[`PCS_CV_DIS_BIT]   = pdis[p];
        end
        else if (sel == `PCS_SEL_STAT)
        begin
            w[`PCS_ST_FAULT_LSB +: 3] = fault[p];
            w[`PCS_ST_CLASS_LSB +: 3] = pclass[p];
            w[`PCS_ST_DONE_BIT]       = done[p];
            w[`PCS_ST_DISC_BIT]       = disc_stat[p];
        end
        return w;
    endfunction

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            reg_rdata  <= `PCS_REG_RESET;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= read_word(reg_port_sel, reg_sel);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output mapping
    for (genvar g = 0; g < NPORT; g++)
    begin : g_out
        assign disc_fault_disable[g] = dfd[g];
        assign dc_disc_disable[g]    = dcd[g];
        assign port_disable[g]       = pdis[g];
        assign conv_start[g]         = conv_go[g];
        assign conv_abort[g]         = abort[g];
        assign port_reset[g]         = op[g][PCS_FN_DISABLE];
        assign discovery1_run[g]     = op[g][PCS_FN_DISC1];
        assign discovery2_run[g]     = op[g][PCS_FN_DISC2];
        assign volt_sample[g]        = op[g][PCS_FN_VSAMPLE];
        assign legacy_detect[g]      = op[g][PCS_FN_LEGACY];
        assign classify_run[g]       = op[g][PCS_FN_CLASSIFY];
        assign power_on[g]           = op[g][PCS_FN_POWER_ON];
        assign cont_sample[g]        = op[g][PCS_FN_CSAMPLE];
        assign ramp_down[g]          = op[g][PCS_FN_RAMPDOWN];
        assign ac_low[g]             = op[g][PCS_FN_AC_LOW];
        assign ac_high[g]            = op[g][PCS_FN_AC_HIGH];
        assign curr_sample[g]        = op[g][PCS_FN_ISAMPLE];
        assign temp_sample[g]        = op[g][PCS_FN_TSAMPLE];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    sequence s_wr(int p, logic [3:0] sel);
        reg_wr && (reg_port_sel == PW'(p)) && (reg_sel == sel);
    endsequence

    sequence s_start_wr(int p);
        s_wr(p, `PCS_SEL_CONV) ##0 reg_wdata[`PCS_CV_START_BIT]
            ##0 !reg_wdata[`PCS_CV_ABORT_BIT];
    endsequence

    for (genvar g = 0; g < NPORT; g++)
    begin : g_chk
        AST_FUNC_RESET : assert property (
            $fell(rst) |-> func[g] == `PCS_FUNC_RESET && port_reset[g]
        ) else $error("Function code not zero after reset");

        AST_FUNC_STORE : assert property (
            s_wr(g, `PCS_SEL_FUNC) |=> func[g] == $past(reg_wdata[3:0])
        ) else $error("Function code not stored");

        AST_POWER_PATH : assert property (
            s_wr(g, `PCS_SEL_FUNC) ##1 (func[g] == PCS_FN_POWER_ON
                                      && !pdis[g])
            |=> power_on[g] && !port_reset[g]
        ) else $error("Power on not decoded");

        AST_DISC1_PATH : assert property (
            (func[g] == PCS_FN_DISC1 && !pdis[g]) |=> discovery1_run[g]
        ) else $error("Discovery step one not decoded");

        AST_SPARE_IDLE : assert property (
            (func[g] > PCS_FN_TSAMPLE && !pdis[g]) |=> op[g] == 13'h0000
        ) else $error("Spare code started an operation");

        AST_DISABLE_OFF : assert property (
            pdis[g] |=> op[g] == 13'h0001
        ) else $error("Disabled port still operating");

        AST_START_PULSE : assert property (
            s_start_wr(g) |=> conv_start[g]
                ##1 (!conv_start[g] || $past(reg_wr))
        ) else $error("Converter start not a pulse");

        AST_START_CLEARS : assert property (
            (conv_start[g] && !reg_wr) |=> !conv_start[g]
        ) else $error("Converter start did not self clear");

        AST_DONE_SET : assert property (
            func_complete[g] |=> done[g]
        ) else $error("Done flag not set");

        AST_DONE_CLEAR : assert property (
            (s_wr(g, `PCS_SEL_FUNC) ##0 !func_complete[g]) |=> !done[g]
        ) else $error("Done flag not cleared by function write");

        AST_DISC_MASK : assert property (
            (dfd[g] && $past(dfd[g])) |-> !disc_stat[g]
        ) else $error("Discovery failure not masked");

        AST_DISC_FAIL : assert property (
            (disc_fail[g] && !dfd[g]) |=> disc_stat[g]
        ) else $error("Discovery failure not reported");

        AST_CLASS_RANGE : assert property (
            pclass[g] <= `PCS_CLASS_MAX
        ) else $error("Class out of range");

        AST_FAULT_LEGAL : assert property (
            fault[g] <= PCS_FLT_LOAD_DISC
        ) else $error("Reserved fault code produced");

        AST_ABORT_BLOCKS : assert property (
            (s_wr(g, `PCS_SEL_CONV) ##0 reg_wdata[`PCS_CV_ABORT_BIT])
            |=> conv_abort[g] && !conv_start[g]
        ) else $error("Abort did not stop conversion start");

        AST_RD_STATUS : assert property (
            (reg_rd && reg_port_sel == PW'(g) && reg_sel == `PCS_SEL_STAT)
            |=> reg_rvalid && reg_rdata == $past({disc_stat[g], done[g],
                                                  pclass[g], fault[g]})
        ) else $error("Status read mismatch");
    end

endmodule

/* pcs_regs_bench.sv */
module pcs_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk, rst, reg_wr, reg_rd, reg_rvalid;
    logic [1:0]  reg_port_sel;
    logic [3:0]  reg_sel;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [3:0]  func_complete, disc_fail, overload, load_disc;
    logic [3:0]  thermal_shutdown_fault, under_over_voltage_fault;
    logic [11:0] class_in;
    logic [3:0]  disc_fault_disable, dc_disc_disable, port_disable;
    logic [3:0]  conv_start, conv_abort, port_reset, discovery1_run;
    logic [3:0]  discovery2_run, volt_sample, legacy_detect, classify_run;
    logic [3:0]  power_on, cont_sample, ramp_down, ac_low, ac_high;
    logic [3:0]  curr_sample, temp_sample;
    bit   [3:0]  dfd, dcd, dis, abt, done, ovl;
    int          fn[4], cls[4], err_count, checked, p;

    pcs_regs #(.NPORT(4), .OVERLOAD_CYCLES(20)) pcs_regs_i
    (
        .mclk, .rst, .reg_port_sel, .reg_sel, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .reg_rvalid, .func_complete, .disc_fail,
        .class_in, .thermal_shutdown_fault, .under_over_voltage_fault,
        .overload, .load_disc, .disc_fault_disable, .dc_disc_disable,
        .port_disable, .conv_start, .conv_abort, .port_reset,
        .discovery1_run, .discovery2_run, .volt_sample, .legacy_detect,
        .classify_run, .power_on, .cont_sample, .ramp_down, .ac_low,
        .ac_high, .curr_sample, .temp_sample
    );

    pcs_host_model pcs_host_model_i
    (
        .mclk, .reg_port_sel, .reg_sel, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////
    // Model of the register bank
    function automatic logic [2:0] flt(int q);
        if (thermal_shutdown_fault[q]) return 3'h2;
        if (under_over_voltage_fault[q]) return 3'h1;
        if (ovl[q]) return 3'h3;
        if (load_disc[q] && !dcd[q]) return 3'h4;
        return 3'h0;
    endfunction

    function automatic logic [7:0] st(int q);
        return {disc_fail[q] & ~dfd[q], done[q], 3'(cls[q]), flt(q)};
    endfunction

    function automatic logic [7:0] fe(int q);
        return {2'h0, dfd[q], dcd[q], 4'(fn[q])};
    endfunction

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(logic [23:0] g, logic [23:0] e);
        checked++;
        if (g !== e)
        begin
            $display("BAD %0t got %h exp %h", $time, g, e);
            err_count++;
        end
    endtask

    task automatic rdc(int q, logic [3:0] s, logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        pcs_host_model_i.rd(2'(q), s, d, ok);
        if (!ok)
        begin
            $display("BAD %0t read timeout", $time);
            err_count++;
            complete_run();
        end
        else
            cmp(24'(d), 24'(e));
    endtask

    task automatic fw(int q, logic [7:0] d);
        pcs_host_model_i.wr(2'(q), 4'h2, d);
        fn[q] = d[3:0];
        dcd[q] = d[4];
        dfd[q] = d[5];
        done[q] = 1'b0;
        if (d[3:0] == 0 || dis[q]) cls[q] = 0;
    endtask

    task automatic cw(int q, logic [7:0] d);
        pcs_host_model_i.wr(2'(q), 4'h3, d);
        dis[q] = d[4];
        abt[q] = d[2];
        if (d[4]) cls[q] = 0;
    endtask

    task automatic fc(int q);
        @(negedge mclk);
        func_complete[q] = 1'b1;
        @(negedge mclk);
        func_complete[q] = 1'b0;
        done[q] = 1'b1;
        if (fn[q] == 5 && !dis[q])
            cls[q] = class_in[3*q+:3] > 4 ? 0 : class_in[3*q+:3];
    endtask

    task automatic chk_dec(int q);
        logic [16:0] g;
        logic [16:0] e;
        g = {port_disable[q], dc_disc_disable[q], disc_fault_disable[q],
             conv_abort[q], temp_sample[q], curr_sample[q], ac_high[q],
             ac_low[q], ramp_down[q], cont_sample[q], power_on[q],
             classify_run[q], legacy_detect[q], volt_sample[q],
             discovery2_run[q], discovery1_run[q], port_reset[q]};
        e = {dis[q], dcd[q], dfd[q], abt[q], 13'h0000};
        if (dis[q] || fn[q] == 0)
            e[0] = 1'b1;
        else if (fn[q] < 13)
            e[fn[q]] = 1'b1;
        cmp(24'(g), 24'(e));
    endtask

    task automatic fset(logic [3:0] v);
        @(negedge mclk);
        {thermal_shutdown_fault[3], under_over_voltage_fault[3],
         overload[3], load_disc[3]} = v;
        repeat (3) @(negedge mclk);
        rdc(3, 4'h4, st(3));
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst = 1'b1;
        {func_complete, disc_fail, overload, load_disc} = 16'h0000;
        {thermal_shutdown_fault, under_over_voltage_fault} = 8'h00;
        class_in = 12'h000;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        void'($urandom(37));
        for (int q = 0; q < 4; q++)
        begin
            rdc(q, 4'h2, 8'h00);
            rdc(q, 4'h3, 8'h00);
            rdc(q, 4'h4, 8'h00);
            chk_dec(q);
        end
        pcs_host_model_i.wr(2'h0, 4'h7, 8'hFF);
        rdc(0, 4'h7, 8'h00);
        rdc(0, 4'h2, fe(0));
        for (int c = 0; c < 16; c++)
        begin
            p = $urandom % 4;
            fw(p, {4'($urandom), 4'(c)});
            @(negedge mclk);
            chk_dec(p);
            rdc(p, 4'h2, fe(p));
            rdc(p, 4'h4, st(p));
        end
        fw(1, 8'h06);
        cw(1, 8'h10);
        @(negedge mclk);
        chk_dec(1);
        rdc(1, 4'h3, 8'h10);
        cw(1, 8'h08);
        cmp(24'(conv_start), 24'h00_0002);
        @(negedge mclk);
        cmp(24'(conv_start), 24'h00_0000);
        rdc(1, 4'h3, 8'h00);
        chk_dec(1);
        cw(1, 8'h0C);
        cmp(24'(conv_start), 24'h00_0000);
        chk_dec(1);
        rdc(1, 4'h3, 8'h04);
        cw(1, 8'h00);
        disc_fail = 4'h1;
        fw(0, 8'h01);
        rdc(0, 4'h4, st(0));
        fw(0, 8'h21);
        rdc(0, 4'h4, st(0));
        disc_fail = 4'h0;
        for (int v = 0; v < 8; v++)
        begin
            fw(2, 8'h05);
            class_in[8:6] = 3'(v);
            fc(2);
            rdc(2, 4'h4, st(2));
        end
        fw(2, 8'h00);
        rdc(2, 4'h4, st(2));
        fw(3, 8'h00);
        fset(4'h8);
        fset(4'hC);
        fset(4'h4);
        fset(4'h1);
        fw(3, 8'h10);
        rdc(3, 4'h4, st(3));
        fset(4'h2);
        repeat (20) @(negedge mclk);
        ovl[3] = 1'b1;
        rdc(3, 4'h4, st(3));
        ovl[3] = 1'b0;
        fset(4'h0);
        for (int q = 0; q < 4; q++)
            rdc(q, 4'h2, fe(q));
        complete_run();
    end
endmodule
